// *** eflt_top.sv ***
// Error flag latch: filters, suppresses and latches sensor faults behind a register port.
`include "eflt_map.svh"

module eflt_top #(
  parameter int DLY_W = 4,
  parameter int TICK_CYC = `EFLT_BUF_TICK_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Analog sense points and checksum checker.
  input wire logic clamp_sense,
  input wire logic overv_sense,
  input wire logic gain_sense,
  input wire logic out_sense,
  input wire logic csum_error,
  // Buffer trigger from the command byte.
  input wire logic buf_trigger,
  // Fault, interrupt, buffer status, switch and checksum mode outputs.
  output logic error_pin_q,
  output logic irq_q,
  output logic buffer_active_status,
  output eflt_pkg::eflt_switch_t switch_q,
  output logic checksum_enable_q
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------

  logic [7:0] config_q;
  logic [7:0] buftim_q;
  logic [4:0] mask_q;
  logic [4:0] status_q;
  logic [4:0] cond_raw;
  logic [4:0] cond_filt;
  logic [4:0] cond_live;
  logic [4:0] status_d;
  logic buf_active;
  logic wr_status;

  // Decodes a write to a given register.
  function automatic logic eflt_hit(input logic [3:0] addr, input logic [3:0] target);
    eflt_hit = (addr == target);
  endfunction : eflt_hit

  assign wr_status = reg_wr && eflt_hit(reg_addr, `EFLT_ADDR_STATUS);

  // Software control registers; switches only change through writes here.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= `EFLT_RST_CONFIG;
      buftim_q <= `EFLT_RST_BUFTIM;
      mask_q <= 5'(`EFLT_RST_MASK);
      switch_q <= eflt_pkg::eflt_switch_t'(5'(`EFLT_RST_SWITCH));
    end else if (reg_wr) begin
      if (eflt_hit(reg_addr, `EFLT_ADDR_CONFIG)) begin
        config_q <= reg_wdata;
      end
      if (eflt_hit(reg_addr, `EFLT_ADDR_BUFTIM)) begin
        buftim_q <= reg_wdata;
      end
      if (eflt_hit(reg_addr, `EFLT_ADDR_MASK)) begin
        mask_q <= reg_wdata[4:0];
      end
      if (eflt_hit(reg_addr, `EFLT_ADDR_SWITCH)) begin
        switch_q <= eflt_pkg::eflt_switch_t'(reg_wdata[4:0]); // [RQ7] [RQ8]
      end
    end
  end

  // Checksum mode follows its configuration bit.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      checksum_enable_q <= 1'b0;
    end else begin
      checksum_enable_q <= config_q[`EFLT_CFG_CSUM];
    end
  end

  // ----------------------------------------
  // Sensor filtering
  // ----------------------------------------

  assign cond_raw = {csum_error, out_sense, gain_sense, overv_sense, clamp_sense};

  // One synchroniser and suppression delay per sensor.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      eflt_sync_filt #(.DLY_W(DLY_W)) u_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw(cond_raw[gi]),
        .delay(config_q[`EFLT_CFG_DLY_MSB:`EFLT_CFG_DLY_LSB]),
        .filt_q(cond_filt[gi])
      ); // [RQ4]
    end
  endgenerate

  // Current buffer timer.
  eflt_buf_timer #(.TICK_CYC(TICK_CYC)) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .trigger(buf_trigger),
    .duration(buftim_q),
    .active_q(buf_active)
  );

  // Live conditions after buffer suppression and checksum gating.
  always_comb begin
    cond_live = buf_active ? 5'h00 : cond_filt; // [RQ5]
    cond_live[`EFLT_BIT_CSUM] = cond_live[`EFLT_BIT_CSUM] && checksum_enable_q; // [RQ6]
  end

  // ----------------------------------------
  // Status latch
  // ----------------------------------------

  // Set wins over write-one-to-clear; latch disable makes flags live.
  always_comb begin
    if (config_q[`EFLT_CFG_LTD]) begin
      status_d = cond_live; // [RQ3]
    end else if (wr_status) begin
      status_d = (status_q & ~reg_wdata[4:0]) | cond_live; // [RQ11] [RQ13]
    end else begin
      status_d = status_q | cond_live; // [RQ1] [RQ9] [RQ10]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 5'h00;
    end else begin
      status_q <= status_d;
    end
  end

  // Error pin and interrupt outputs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      error_pin_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      error_pin_q <= |status_d; // [RQ2]
      irq_q <= |(status_d & mask_q);
    end
  end

  assign buffer_active_status = buf_active; // [RQ12]

  // ----------------------------------------
  // Read port
  // ----------------------------------------

  // Read data stand one cycle after the read strobe, zero otherwise.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `EFLT_ADDR_STATUS: reg_rdata_q <= {2'b00, buf_active, status_q};
        `EFLT_ADDR_MASK: reg_rdata_q <= {3'b000, mask_q};
        `EFLT_ADDR_CONFIG: reg_rdata_q <= config_q;
        `EFLT_ADDR_BUFTIM: reg_rdata_q <= buftim_q;
        `EFLT_ADDR_SWITCH: reg_rdata_q <= {3'b000, switch_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (status_q[0] && !config_q[`EFLT_CFG_LTD] && !wr_status) |=> status_q[0])
    else $error("Latched flag dropped without clear."); // [RQ1]
  AST_PIN_OR: assert property (@(posedge clk) disable iff (!reset_n)
    error_pin_q == |status_q) else $error("Error pin differs from flag OR."); // [RQ2]
  AST_LIVE_MODE: assert property (@(posedge clk) disable iff (!reset_n)
    config_q[`EFLT_CFG_LTD] |=> status_q == $past(cond_live))
    else $error("Unlatched flag not live."); // [RQ3]
  AST_SUPPRESS: assert property (@(posedge clk) disable iff (!reset_n)
    (buf_active && status_q == 5'h00 && !config_q[`EFLT_CFG_LTD]) |=> status_q == 5'h00)
    else $error("Flag set during buffer active."); // [RQ5]
  AST_CSUM_GATE: assert property (@(posedge clk) disable iff (!reset_n)
    (!checksum_enable_q && !status_q[4]) |=> !status_q[4])
    else $error("Checksum flag set while disabled."); // [RQ6]
  AST_CLEAR_ALL: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_status && reg_wdata == 8'hFF && cond_live == 5'h00) |=> status_q == 5'h00)
    else $error("Clear all left a flag."); // [RQ11]
  AST_RESET_AGAIN: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_status && cond_live != 5'h00) |=> ((status_q & $past(cond_live)) == $past(cond_live)))
    else $error("Present condition not set again."); // [RQ13]
  AST_SWITCH_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    !(reg_wr && eflt_hit(reg_addr, `EFLT_ADDR_SWITCH)) |=> $stable(switch_q))
    else $error("Switch changed without write."); // [RQ7]

endmodule : eflt_top

// *** eflt_map.svh ***
// Register offsets, field positions, reset values and timing counts of the error flag latch.
// Behaviour
// RQ1 - Every detected out-of-range condition is latched in the error status register until cleared.
// RQ2 - All flags are ORed onto one output pin usable as error interrupt.
// RQ3 - Flags latch by default; latch-disable makes flags follow live conditions.
// RQ4 - Each sensor passes a programmable suppression delay; shorter pulses are ignored.
// RQ5 - Error signals are suppressed while the input current buffer is active.
// RQ6 - Checksum fault flag can only be set with checksum mode enabled.
// RQ7 - Input test switches are controlled only by serial register writes.
// RQ8 - Switches: short to ground, disconnect, test current, discharge, ground-referenced.
// RQ9 - A distinct flag records input clamp conduction.
// RQ10 - Separate flags for input overvoltage, gain overload and output stage fault.
// RQ11 - Writing all ones to error status clears every flag.
// RQ12 - Buffer-active status bit is high while the current buffer runs.
// RQ13 - A cleared flag with its condition still present sets again next clock.
`ifndef EFLT_MAP_SVH
`define EFLT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EFLT_ADDR_SWITCH 4'h2
`define EFLT_ADDR_BUFTIM 4'h3
`define EFLT_ADDR_STATUS 4'h4
`define EFLT_ADDR_MASK 4'h5
`define EFLT_ADDR_CONFIG 4'hB

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EFLT_BIT_CLAMP 0
`define EFLT_BIT_OVERV 1
`define EFLT_BIT_GAIN 2
`define EFLT_BIT_OUT 3
`define EFLT_BIT_CSUM 4
`define EFLT_BIT_BUFFER_ACTIVE_STATUS 5
`define EFLT_CFG_LTD 7
`define EFLT_CFG_CSUM 6
`define EFLT_CFG_DLY_LSB 0
`define EFLT_CFG_DLY_MSB 3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define EFLT_RST_BUFTIM 8'h19
`define EFLT_RST_CONFIG 8'h00
`define EFLT_RST_MASK 8'h1F
`define EFLT_RST_SWITCH 8'h00
`define EFLT_BUF_TICK_NS 1000
`define EFLT_CLK_NS 8
`define EFLT_BUF_TICK_CYC ((`EFLT_BUF_TICK_NS + `EFLT_CLK_NS - 1) / `EFLT_CLK_NS)

`endif

// *** eflt_pkg.sv ***
// Types shared by the error flag latch files.
package eflt_pkg;

  // One bit per detected condition.
  typedef struct packed {
    logic csum;
    logic out_stage;
    logic gain;
    logic overv;
    logic clamp;
  } eflt_cond_t;

  // Input switch controls driven by register writes.
  typedef struct packed {
    logic ground_ref;
    logic discharge;
    logic test_current;
    logic disconnect;
    logic short_gnd;
  } eflt_switch_t;

  // States of the current buffer timer.
  typedef enum logic [1:0] {
    EFLT_BUF_IDLE = 2'b01,
    EFLT_BUF_RUN = 2'b10
  } eflt_buf_state_t;

endpackage : eflt_pkg

// *** eflt_sync_filt.sv ***
// Two-flop synchroniser followed by a suppression delay filter for one sensor.
`include "eflt_map.svh"

module eflt_sync_filt #(
  parameter int DLY_W = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Raw sensor and programmed delay.
  input wire logic raw,
  input wire logic [DLY_W-1:0] delay,
  // Filtered level.
  output logic filt_q
);

  logic s1_q;
  logic s2_q;
  logic [DLY_W-1:0] cnt_q;

  // Synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // Level must hold for delay cycles before it passes.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (!s2_q) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (cnt_q >= delay) begin
      filt_q <= 1'b1; // [RQ4]
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // A sensor pulse must be seen before the filter passes it.
  AST_FILT_NEEDS_INPUT: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(filt_q) |-> $past(s2_q)) else $error("Filter rose without input."); // [RQ4]

endmodule : eflt_sync_filt

// *** eflt_buf_timer.sv ***
// Current buffer active timer started by a trigger, counted in microsecond ticks.
`include "eflt_map.svh"

module eflt_buf_timer #(
  parameter int TICK_CYC = `EFLT_BUF_TICK_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Trigger and programmed duration in ticks.
  input wire logic trigger,
  input wire logic [7:0] duration,
  // Active level.
  output logic active_q
);

  eflt_pkg::eflt_buf_state_t state_q;
  logic [7:0] ticks_q;
  logic [15:0] pre_q;

  // Runs for duration ticks after a trigger, retriggerable.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= eflt_pkg::EFLT_BUF_IDLE;
      ticks_q <= 8'h00;
      pre_q <= 16'h0000;
      active_q <= 1'b0;
    end else if (trigger && duration != 8'h00) begin
      state_q <= eflt_pkg::EFLT_BUF_RUN;
      ticks_q <= duration;
      pre_q <= 16'h0000;
      active_q <= 1'b1; // [RQ12]
    end else begin
      case (state_q)
        eflt_pkg::EFLT_BUF_IDLE: begin
          active_q <= 1'b0;
        end
        eflt_pkg::EFLT_BUF_RUN: begin
          if (pre_q == 16'(TICK_CYC - 1)) begin
            pre_q <= 16'h0000;
            if (ticks_q == 8'h01) begin
              state_q <= eflt_pkg::EFLT_BUF_IDLE;
              active_q <= 1'b0;
            end
            ticks_q <= ticks_q - 8'h01;
          end else begin
            pre_q <= pre_q + 16'h0001;
          end
        end
        default: begin
          state_q <= eflt_pkg::EFLT_BUF_IDLE;
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // Active follows the running state.
  AST_BUF_ACTIVE_STATE: assert property (@(posedge clk) disable iff (!reset_n)
    active_q == (state_q == eflt_pkg::EFLT_BUF_RUN)) else $error("Buffer status mismatch."); // [RQ12]

endmodule : eflt_buf_timer

// *** eflt_host_model.sv ***
// Register port host model that configures the block and reads and clears its flags.
module eflt_host_model (
  // Clock.
  input wire logic clk,
  // Register port.
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; switches and flag clears are set only this way.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read; the data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rd
endmodule : eflt_host_model

// *** testbench.sv ***
// Self-checking bench of the error flag latch.
`include "eflt_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_q;
  eflt_pkg::eflt_cond_t cond = '0;
  logic buf_trigger = 1'b0;
  logic error_pin_q;
  logic irq_q;
  logic buffer_active_status;
  eflt_pkg::eflt_switch_t switch_q;
  logic checksum_enable_q;
  int mismatches = 0;
  int total_checks = 0;

  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk = ~clk;
  end

  eflt_host_model eflt_host_model_inst (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  eflt_top #(.DLY_W(4), .TICK_CYC(2)) eflt_top_inst (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .clamp_sense(cond.clamp), .overv_sense(cond.overv),
    .gain_sense(cond.gain), .out_sense(cond.out_stage), .csum_error(cond.csum),
    .buf_trigger(buf_trigger), .error_pin_q(error_pin_q), .irq_q(irq_q),
    .buffer_active_status(buffer_active_status), .switch_q(switch_q),
    .checksum_enable_q(checksum_enable_q));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Compares a seen value with the expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Reads a register and compares it.
  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    eflt_host_model_inst.rd(a, d);
    check(d, exp);
  endtask : expect_reg

  task automatic clear_all();
    eflt_host_model_inst.wr(`EFLT_ADDR_STATUS, 8'hFF);
    idle(3);
  endtask : clear_all

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    int n;
    idle(20);
    reset_n <= 1'b1;
    expect_reg(`EFLT_ADDR_BUFTIM, 8'h19);
    expect_reg(`EFLT_ADDR_MASK, 8'h1F);
    expect_reg(`EFLT_ADDR_CONFIG, 8'h00);
    expect_reg(`EFLT_ADDR_STATUS, 8'h00);
    expect_reg(4'h7, 8'h00);
    // Each analog flag latches, drives the pin and clears with all ones.
    for (int i = 0; i < 4; i++) begin
      cond <= eflt_pkg::eflt_cond_t'(5'h01 << i);
      idle(12);
      expect_reg(`EFLT_ADDR_STATUS, 8'h01 << i);
      cond <= '0;
      idle(12);
      expect_reg(`EFLT_ADDR_STATUS, 8'h01 << i);
      check({7'h00, error_pin_q & irq_q}, 8'h01);
      clear_all();
      expect_reg(`EFLT_ADDR_STATUS, 8'h00);
      check({7'h00, error_pin_q}, 8'h00);
    end
    // Masked flag still reaches the pin; a clear with the cause held sets again.
    eflt_host_model_inst.wr(`EFLT_ADDR_MASK, 8'h00);
    cond <= 5'h01;
    idle(12);
    check({6'h00, error_pin_q, irq_q}, 8'h02);
    clear_all();
    expect_reg(`EFLT_ADDR_STATUS, 8'h01);
    cond <= '0;
    idle(8);
    clear_all();
    eflt_host_model_inst.wr(`EFLT_ADDR_MASK, 8'h1F);
    // Latch disabled: the flag follows its condition.
    eflt_host_model_inst.wr(`EFLT_ADDR_CONFIG, 8'h80);
    cond <= 5'h02;
    idle(12);
    expect_reg(`EFLT_ADDR_STATUS, 8'h02);
    cond <= '0;
    idle(12);
    expect_reg(`EFLT_ADDR_STATUS, 8'h00);
    // Checksum flag only with checksum mode on.
    eflt_host_model_inst.wr(`EFLT_ADDR_CONFIG, 8'h00);
    cond <= 5'h10;
    idle(12);
    expect_reg(`EFLT_ADDR_STATUS, 8'h00);
    eflt_host_model_inst.wr(`EFLT_ADDR_CONFIG, 8'h40);
    idle(12);
    expect_reg(`EFLT_ADDR_STATUS, 8'h10);
    check({7'h00, checksum_enable_q}, 8'h01);
    cond <= '0;
    idle(8);
    clear_all();
    // Longest delay: a short pulse is dropped, a long one sets the flag.
    eflt_host_model_inst.wr(`EFLT_ADDR_CONFIG, 8'h0F);
    cond <= 5'h04;
    idle(4);
    cond <= '0;
    idle(30);
    expect_reg(`EFLT_ADDR_STATUS, 8'h00);
    cond <= 5'h04;
    idle(40);
    expect_reg(`EFLT_ADDR_STATUS, 8'h04);
    cond <= '0;
    eflt_host_model_inst.wr(`EFLT_ADDR_CONFIG, 8'h00);
    idle(25);
    clear_all();
    // Buffer active: busy bit shows and conditions are suppressed.
    eflt_host_model_inst.wr(`EFLT_ADDR_BUFTIM, 8'h0A);
    @(posedge clk);
    buf_trigger <= 1'b1;
    @(posedge clk);
    buf_trigger <= 1'b0;
    idle(2);
    check({7'h00, buffer_active_status}, 8'h01);
    expect_reg(`EFLT_ADDR_STATUS, 8'h20);
    cond <= 5'h01;
    idle(5);
    cond <= '0;
    n = 0;
    while (buffer_active_status === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (n >= 100) begin
      mismatches++;
      tally_and_finish();
    end
    idle(12);
    expect_reg(`EFLT_ADDR_STATUS, 8'h00);
    // Every input switch function is set by a register write.
    for (int i = 0; i < 5; i++) begin
      eflt_host_model_inst.wr(`EFLT_ADDR_SWITCH, 8'h01 << i);
      idle(2);
      check({3'h0, switch_q}, 8'h01 << i);
    end
    tally_and_finish();
  end
endmodule : testbench
